// *** include/pmicev_regs.svh ***
// register offsets, field positions and reset values of the event block
`ifndef PMICEV_REGS_SVH
`define PMICEV_REGS_SVH
`define PMICEV_ADDR_EVENT 8'h02
`define PMICEV_ADDR_CHG 8'h03
`define PMICEV_EV_REMOVED 0
`define PMICEV_EV_APPLIED 1
`define PMICEV_EV_BUTTON 2
`define PMICEV_EV_TOUCH 3
`define PMICEV_MASK_BUTTON 5
`define PMICEV_MASK_TOUCH 6
`define PMICEV_MASK_SUPPLY 7
`define PMICEV_CHG_THERMAL 7
`define PMICEV_CHG_PATH_LIMIT 6
`define PMICEV_CHG_SUSPEND 5
`define PMICEV_CHG_TERM 4
`define PMICEV_CHG_SAFETY_EXP 2
`define PMICEV_CHG_PRETIMEOUT 1
`define PMICEV_CHG_TEMP_FAULT 0
`define PMICEV_EVENT_RESET 8'h00
`endif

// *** include/pmicev_pkg.sv ***
// types shared by the event block
package pmicev_pkg;
   typedef logic [7:0] pmicev_byte_t;
   typedef enum logic [0:0] {
      PMICEV_IDLE = 1'b0,
      PMICEV_READ = 1'b1
   } pmicev_rd_e;
endpackage

// *** rtl/pmicev_edge.sv ***
// synchronous rising and falling edge detector
module pmicev_edge #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // level in, edge pulses out
   input wire logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] fall
);
   if (WIDTH < 1) begin : g_width_check
      $error("pmicev_edge: WIDTH must be at least 1");
   end

   logic [WIDTH-1:0] prev;
   logic [WIDTH-1:0] next_prev;

   always_comb begin
      next_prev = level;
      rise = level & ~prev;
      fall = ~level & prev;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prev <= '0;
      end else begin
         prev <= next_prev;
      end
   end
endmodule

// *** rtl/pmicev_top.sv ***
// event flags, interrupt masking and charger status of the power manager
`include "pmicev_regs.svh"

// Function
// R1: button mask bit 5 gates a button event onto the low interrupt pin.
// R2: touch flag bit 3 sets on a touch and holds until the register is read.
// R3: button flag bit 2 sets when the button goes to its active level and holds until read.
// R4: applied flag bit 1 sets when either supply appears and holds until read.
// R5: removed flag bit 0 sets when either supply vanishes and holds until read.
// R6: status bit 7 shows thermal current reduction.
// R7: status bit 6 shows the dynamic power path limit loop active.
// R8: status bit 4 shows termination current crossed and charging stopped.
// R9: status bits 2 and 1 show charge and precharge timer expiry.
// R10: status bit 0 shows a battery temperature fault or missing sensor.
// R11: touch mask bit 6 gates a touch flag onto the interrupt pin.
// R12: supply mask bit 7 gates either supply flag onto the interrupt pin.
// R13: pin releases when no enabled flag pends; reading clears all flags (a flag whose event comes in the read cycle stays set).
module pmicev_top #(
   parameter bit BUTTON_ACTIVE_HIGH = 1'b0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // event sources
   input wire logic touch_controller,
   input wire logic pushbutton_input,
   input wire logic usb_present,
   input wire logic ac_present,
   // charger state
   input wire logic thermal_regulation,
   input wire logic dynamic_path_power_limit,
   input wire logic thermal_suspend,
   input wire logic termination_reached,
   input wire logic charge_timer_expired,
   input wire logic precharge_timer_expired,
   input wire logic battery_temp_fault,
   // open-drain interrupt pin, active low
   output logic int_n_o,
   output logic int_n_oe
);
   // ----------------------------------------------------------------
   // event detection
   // ----------------------------------------------------------------
   logic [3:0] rise;
   logic [3:0] fall;
   logic button_active;

   always_comb begin
      button_active = BUTTON_ACTIVE_HIGH ? pushbutton_input
                                         : ~pushbutton_input; // see R3
   end

   // history starts at zero: a supply present at reset counts as applied
   pmicev_edge #(.WIDTH(4)) u_edge (
      .clk(clk),
      .rst(rst),
      .level({ac_present, usb_present, button_active, touch_controller}),
      .rise(rise),
      .fall(fall)
   );

   // ----------------------------------------------------------------
   // event register
   // ----------------------------------------------------------------
   pmicev_pkg::pmicev_byte_t event_reg;
   pmicev_pkg::pmicev_byte_t next_event_reg;
   pmicev_pkg::pmicev_byte_t chg_status;
   logic [7:0] next_rdata;
   logic next_int;
   logic ev_read;
   logic [3:0] set_ev;

   always_comb begin
      ev_read = reg_rd && (reg_addr == `PMICEV_ADDR_EVENT);
      set_ev = '0;
      set_ev[`PMICEV_EV_TOUCH] = rise[0]; // see R2
      set_ev[`PMICEV_EV_BUTTON] = rise[1]; // see R3
      set_ev[`PMICEV_EV_APPLIED] = rise[2] | rise[3]; // see R4
      set_ev[`PMICEV_EV_REMOVED] = fall[2] | fall[3]; // see R5
      next_event_reg = event_reg;
      // read clears, a same-cycle event still sets
      if (ev_read) begin
         next_event_reg[3:0] = 4'h0; // see R13
      end
      next_event_reg[3:0] = next_event_reg[3:0] | set_ev;
      if (reg_wr && reg_addr == `PMICEV_ADDR_EVENT) begin
         next_event_reg[7:5] = reg_wdata[7:5];
      end
      next_event_reg[4] = 1'b0;
   end

   // ----------------------------------------------------------------
   // charger status and read data
   // ----------------------------------------------------------------
   always_comb begin
      chg_status = '0;
      chg_status[`PMICEV_CHG_THERMAL] = thermal_regulation; // see R6
      chg_status[`PMICEV_CHG_PATH_LIMIT] = dynamic_path_power_limit; // see R7
      chg_status[`PMICEV_CHG_SUSPEND] = thermal_suspend;
      chg_status[`PMICEV_CHG_TERM] = termination_reached; // see R8
      chg_status[`PMICEV_CHG_SAFETY_EXP] = charge_timer_expired; // see R9
      chg_status[`PMICEV_CHG_PRETIMEOUT] = precharge_timer_expired; // see R9
      chg_status[`PMICEV_CHG_TEMP_FAULT] = battery_temp_fault; // see R10
      // registered every cycle, follows the address
      unique case (reg_addr)
         `PMICEV_ADDR_EVENT: next_rdata = event_reg;
         `PMICEV_ADDR_CHG: next_rdata = chg_status;
         default: next_rdata = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------
   // interrupt pin
   // ----------------------------------------------------------------
   always_comb begin
      next_int =
         (next_event_reg[`PMICEV_MASK_BUTTON]
          & next_event_reg[`PMICEV_EV_BUTTON]) // see R1
       | (next_event_reg[`PMICEV_MASK_TOUCH]
          & next_event_reg[`PMICEV_EV_TOUCH]) // see R11
       | (next_event_reg[`PMICEV_MASK_SUPPLY]
          & (next_event_reg[`PMICEV_EV_APPLIED]
             | next_event_reg[`PMICEV_EV_REMOVED])); // see R12
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         event_reg <= `PMICEV_EVENT_RESET;
         reg_rdata <= 8'h00;
         int_n_oe <= 1'b0;
         int_n_o <= 1'b0;
      end else begin
         event_reg <= next_event_reg;
         reg_rdata <= next_rdata;
         int_n_oe <= next_int; // see R13
         int_n_o <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   touch_sets_a: assert property (rise[0] |=> event_reg[3]) // see R2
      else $error("touch flag not set");
   button_sets_a: assert property (rise[1] |=> event_reg[2]) // see R3
      else $error("button flag not set");
   applied_sets_a: assert property (rise[3:2] != 2'b00
      |=> event_reg[1]) // see R4
      else $error("applied flag not set");
   removed_sets_a: assert property (fall[3:2] != 2'b00
      |=> event_reg[0]) // see R5
      else $error("removed flag not set");
   read_clears_a: assert property (ev_read && set_ev == 4'h0
      |=> event_reg[3:0] == 4'h0) // see R13
      else $error("read did not clear flags");
   flag_holds_a: assert property (!ev_read && event_reg[3]
      |=> event_reg[3]) // see R2
      else $error("touch flag lost without read");
   button_mask_a: assert property (event_reg[2] && event_reg[5]
      && !ev_read && !reg_wr |=> int_n_oe) // see R1
      else $error("button interrupt missing");
   touch_mask_a: assert property (!event_reg[6] && !event_reg[7]
      && !event_reg[5] && !reg_wr |=> !int_n_oe) // see R11
      else $error("masked interrupt asserted");
   supply_int_a: assert property (event_reg[7] && event_reg[0]
      && !ev_read && !reg_wr |=> int_n_oe) // see R12
      else $error("supply interrupt missing");
   status_read_a: assert property (reg_addr == `PMICEV_ADDR_CHG
      |=> reg_rdata[7] == $past(thermal_regulation)
          && reg_rdata[0] == $past(battery_temp_fault)) // see R6
      else $error("charger status wrong");
   timer_read_a: assert property (reg_addr == `PMICEV_ADDR_CHG
      |=> reg_rdata[2:1] == $past({charge_timer_expired,
          precharge_timer_expired})) // see R9
      else $error("timer status wrong");

   path_read_a: assert property (reg_addr == `PMICEV_ADDR_CHG
      |=> reg_rdata[6] == $past(dynamic_path_power_limit)) // see R7
      else $error("power path limit status wrong");
   term_read_a: assert property (reg_addr == `PMICEV_ADDR_CHG
      |=> reg_rdata[4] == $past(termination_reached)) // see R8
      else $error("termination status wrong");
   touch_int_a: assert property (event_reg[3] && event_reg[6]
      && !ev_read && !reg_wr |=> int_n_oe) // see R11
      else $error("touch interrupt missing");
   applied_int_a: assert property (event_reg[7] && event_reg[1]
      && !ev_read && !reg_wr |=> int_n_oe) // see R12
      else $error("applied interrupt missing");
   pin_release_a: assert property (ev_read && set_ev == 4'h0
      |=> !int_n_oe) // see R13
      else $error("interrupt pin not released");
   race_set_a: assert property (ev_read && set_ev[3]
      |=> event_reg[3]) // see R2
      else $error("touch lost in read cycle");
   button_holds_a: assert property (!ev_read && event_reg[2]
      |=> event_reg[2]) // see R3
      else $error("button flag lost without read");
   applied_holds_a: assert property (!ev_read && event_reg[1]
      |=> event_reg[1]) // see R4
      else $error("applied flag lost without read");
   removed_holds_a: assert property (!ev_read && event_reg[0]
      |=> event_reg[0]) // see R5
      else $error("removed flag lost without read");
   mask_write_a: assert property (reg_wr && reg_addr == `PMICEV_ADDR_EVENT
      |=> event_reg[7:5] == $past(reg_wdata[7:5])) // see R1
      else $error("mask write lost");
   event_read_a: assert property (reg_addr == `PMICEV_ADDR_EVENT
      |=> reg_rdata == $past(event_reg)) // see R2
      else $error("event read data wrong");
   unmapped_read_a: assert property (reg_addr != `PMICEV_ADDR_EVENT
      && reg_addr != `PMICEV_ADDR_CHG |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");

   touch_irq_c: cover property (rise[0] && event_reg[6] ##1 int_n_oe);
   read_release_c: cover property (int_n_oe && ev_read ##1 !int_n_oe);
   supply_c: cover property (rise[2] ##[1:20] fall[2]);
   button_irq_c: cover property (rise[1] && event_reg[5] ##1 int_n_oe);
   clear_race_c: cover property (ev_read && set_ev != 4'h0);
endmodule

// *** bench/pmicev_host.sv ***
// host side of the open-drain interrupt line
module pmicev_host (
   // pin from the device
   input wire logic int_n_o,
   input wire logic int_n_oe,
   // level seen by the host
   output logic int_line
);
   timeunit 1ns;
   timeprecision 1ps;
   // released line rises to the pull-up level
   assign int_line = int_n_oe ? int_n_o : 1'b1;
endmodule

// *** bench/tb_top.sv ***
// self-checking bench of the event flags and charger status block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, reg_wr, reg_rd, touch, pb, usb, ac, int_n_o, int_n_oe;
   logic int_line;
   logic [7:0] addr, wdata, rdata, v, lf;
   logic [6:0] st;
   int error_cnt = 0;
   int total_checks = 0;
   pmicev_top uut (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(wdata), .reg_rdata(rdata),
      .touch_controller(touch), .pushbutton_input(pb), .usb_present(usb),
      .ac_present(ac), .thermal_regulation(st[6]),
      .dynamic_path_power_limit(st[5]), .thermal_suspend(st[4]),
      .termination_reached(st[3]), .charge_timer_expired(st[2]),
      .precharge_timer_expired(st[1]), .battery_temp_fault(st[0]),
      .int_n_o(int_n_o), .int_n_oe(int_n_oe));
   pmicev_host host (.int_n_o(int_n_o), .int_n_oe(int_n_oe),
      .int_line(int_line));
   // -----------------------------------------
   // helpers
   // -----------------------------------------
   function automatic logic [7:0] nxt(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [7:0] exp_chg(input logic [6:0] s);
      return {s[6:3], 1'b0, s[2:0]};
   endfunction
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chkb(input logic g, input logic e);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(negedge clk);
      addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      v = rdata;
   endtask
   // one event, button or touch source released a cycle later, usb level left as set
   task automatic ev(input int k);
      @(negedge clk);
      case (k)
         0: usb = 1'b0;
         1: usb = 1'b1;
         2: pb = 1'b0;
         default: touch = 1'b1;
      endcase
      @(negedge clk);
      pb = 1'b1;
      touch = 1'b0;
   endtask
   task automatic give_verdict;
      $display("checks=%0d errors=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // -----------------------------------------
   // clock, watchdog and sequence
   // -----------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #100us;
      error_cnt++;
      give_verdict;
   end
   initial begin
      {rst, reg_wr, reg_rd, touch, pb, usb, ac} = 7'h44;
      {addr, wdata, st, lf} = {8'h00, 8'h00, 7'h00, 8'h59};
      repeat (5) @(negedge clk);
      chk8(rdata, 8'h00);
      chkb(int_line, 1'b1);
      rst = 1'b0;
      rd(8'h02);
      chk8(v, 8'h00);
      wr(8'h02, 8'hFF);
      rd(8'h02);
      chk8(v, 8'hE0);
      for (int k = 3; k >= 0; k--) begin
         ev(k);
         chkb(int_line, 1'b0);
         rd(8'h02);
         chk8(v, 8'hE0 | (8'h01 << k));
         chkb(int_line, 1'b1);
      end
      wr(8'h02, 8'h00);
      ev(3);
      chkb(int_line, 1'b1);
      ev(2);
      chkb(int_line, 1'b1);
      ev(1);
      chkb(int_line, 1'b1);
      rd(8'h02);
      chk8(v, 8'h0E);
      wr(8'h02, 8'h80);
      ac = 1'b1;
      ev(0);
      chkb(int_line, 1'b0);
      rd(8'h02);
      chk8(v, 8'h83);
      @(negedge clk);
      {addr, reg_rd, touch} = {8'h02, 1'b1, 1'b1};
      @(negedge clk);
      {reg_rd, touch} = 2'b00;
      chk8(rdata, 8'h80);
      rd(8'h02);
      chk8(v, 8'h88);
      for (int i = 0; i < 10; i++) begin
         lf = nxt(lf);
         st = (i == 0) ? 7'h7F : lf[6:0];
         rd(8'h03);
         chk8(v, exp_chg(st));
      end
      wr(8'h03, 8'hFF);
      rd(8'h03);
      chk8(v, exp_chg(st));
      rd(8'h7F);
      chk8(v, 8'h00);
      give_verdict;
   end
endmodule
